// [logic/sdr_pkg.sv]
// constants shared by the sdram read path block
package sdr_pkg;
  // command codes as {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_LMR = 4'h0;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_BST = 4'h6;
  // mode word layout
  localparam int MODE_W = 10;
  localparam int BL_LSB = 0;
  localparam int BT_BIT = 3;
  localparam int LAT_LSB = 4;
  localparam int OPM_LSB = 7;
  localparam int WBM_BIT = 9;
  localparam int AP_BIT = 10;
  localparam logic [MODE_W-1:0] MODE_RESET = 10'h030;
  // burst length codes
  localparam logic [2:0] BL_1 = 3'h0;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;
  // read latency codes and operating mode
  localparam logic [2:0] LAT_2 = 3'h2;
  localparam logic [2:0] LAT_3 = 3'h3;
  localparam logic [1:0] OPM_NORMAL = 2'h0;
  // apb register byte offsets
  localparam logic [7:0] REG_MODE = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_WORDS = 8'h08;
  // status register bit positions
  localparam int ST_BANK_LSB = 0;
  localparam int ST_RD_ACT = 4;
  localparam int ST_WR_ACT = 5;
  localparam int ST_RESERVED = 6;
  localparam int ST_BAD_WRITE = 7;
  localparam int ST_LAT3 = 8;
  localparam int NUM_BANKS = 4;
endpackage

// [logic/sdr_read_path.sv]
// sdram device read path: mode, bank activation, read and write bursts, apb view
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - write-burst-mode clear: bursts for both; set: writes touch one column only
// - READ carries column, bank and auto-precharge; precharge follows burst end
// - first word one read latency after READ, then one word per clock
// - finished burst with no new command releases the data pins
// - continuous-page read runs until stopped, wrapping the column to zero
// - a READ is accepted on any clock after a READ, any bank
// - mask high two clocks before WRITE; mask reaches output two clocks later
// - truncating WRITE forces pins off if mask was high the clock before
// - mask dropped before WRITE; input masking acts with no delay
// - burst terminate ends page or fixed read, read latency minus one early
// - latency two or three; pins drive after edge n+m-1, valid by n+m
// - mode word: burst length bits 2:0, type bit 3, latency bits 6:4
module sdr_read_path #(
  parameter int COL_W = 8,
  parameter int ADDR_W = 12,
  parameter int DQ_W = 16
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic pready, // apb ready
  output logic [31:0] prdata, // apb read data
  output logic pslverr, // apb error, unmapped address
  input wire logic cs_n, // chip select, active low
  input wire logic ras_n, // row strobe, active low
  input wire logic cas_n, // column strobe, active low
  input wire logic we_n, // write enable, active low
  input wire logic [1:0] ba, // bank address
  input wire logic [ADDR_W-1:0] addr, // row, column, mode and precharge bits
  input wire logic dqm, // byte mask, high masks
  input wire logic [DQ_W-1:0] dq_in, // data pins as seen from outside
  output logic [DQ_W-1:0] dq_out, // read data driven
  output logic dq_oe // high while data pins are driven
);

  localparam int NB = sdr_pkg::NUM_BANKS;

  // command decode
  logic [3:0] cmd;
  logic is_lmr, is_act, is_pre, is_read, is_write, is_bst;
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  assign is_lmr = (cmd == sdr_pkg::CMD_LMR);
  assign is_act = (cmd == sdr_pkg::CMD_ACT);
  assign is_pre = (cmd == sdr_pkg::CMD_PRE);
  assign is_read = (cmd == sdr_pkg::CMD_READ);
  assign is_write = (cmd == sdr_pkg::CMD_WRITE);
  assign is_bst = (cmd == sdr_pkg::CMD_BST);

  logic [sdr_pkg::MODE_W-1:0] mode;
  logic [2:0] bl_code;
  logic page, lat3, wbm, il;
  logic [COL_W-1:0] rmask, wmask;
  logic [COL_W-1:0] cmd_col;

  // mode fields
  assign bl_code = mode[sdr_pkg::BL_LSB +: 3];
  assign page = (bl_code == sdr_pkg::BL_PAGE);
  assign lat3 = (mode[sdr_pkg::LAT_LSB +: 3] == sdr_pkg::LAT_3);
  assign wbm = mode[sdr_pkg::WBM_BIT];
  assign il = mode[sdr_pkg::BT_BIT] && !page;
  assign cmd_col = addr[COL_W-1:0];

  // block mask for a burst length code
  function automatic logic [COL_W-1:0] blk_mask(input logic [2:0] code);
    logic [COL_W-1:0] m;
    m = '0;
    case (code)
      sdr_pkg::BL_2: m = COL_W'(1);
      sdr_pkg::BL_4: m = COL_W'(3);
      sdr_pkg::BL_8: m = COL_W'(7);
      sdr_pkg::BL_PAGE: m = '1;
      default: m = '0;
    endcase
    return m;
  endfunction

  // k-th column of a burst, wrapping inside the block
  function automatic logic [COL_W-1:0] col_of(input logic [COL_W-1:0] s,
      input logic [COL_W-1:0] k, input logic [COL_W-1:0] m, input logic ilv);
    logic [COL_W-1:0] c;
    c = ilv ? (s ^ (k & m)) : ((s & ~m) | ((s + k) & m));
    return c;
  endfunction

  assign rmask = blk_mask(bl_code);
  assign wmask = wbm ? '0 : rmask;

  // read burst engine state
  logic rd_active, rd_ap;
  logic [COL_W-1:0] rd_start, rd_k, rd_col;
  logic [1:0] rd_bank;
  logic rd_stop, rd_last, emit, ap_close;
  logic [COL_W-1:0] e_col;
  logic [1:0] e_bank, ap_bank;

  assign rd_col = col_of(rd_start, rd_k, rmask, il);
  // a new read, a write, a terminate or a precharge of the bank ends the burst
  assign rd_stop = is_read || is_write || is_bst
    || (is_pre && (addr[sdr_pkg::AP_BIT] || ba == rd_bank));
  assign rd_last = !page && (rd_k == rmask);

  // word issued into the output pipeline this edge
  always_comb
  begin
    emit = 1'b0;
    e_col = rd_col;
    e_bank = rd_bank;
    if (is_read)
    begin
      emit = 1'b1;
      e_col = cmd_col;
      e_bank = ba;
    end
    else if (rd_active && !rd_stop)
    begin
      emit = 1'b1;
    end
  end

  // auto precharge closes the bank when its burst finishes
  always_comb
  begin
    ap_close = 1'b0;
    ap_bank = rd_bank;
    if (is_read && addr[sdr_pkg::AP_BIT] && !page && rmask == '0)
    begin
      ap_close = 1'b1;
      ap_bank = ba;
    end
    else if (rd_active && rd_ap && !rd_stop && rd_last)
    begin
      ap_close = 1'b1;
    end
  end

  // read burst counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rd_active <= 1'b0;
      rd_ap <= 1'b0;
      rd_start <= '0;
      rd_k <= '0;
      rd_bank <= '0;
    end
    else if (is_read)
    begin
      rd_active <= page || (rmask != '0);
      rd_ap <= addr[sdr_pkg::AP_BIT] && !page;
      rd_start <= cmd_col;
      rd_k <= COL_W'(1);
      rd_bank <= ba;
    end
    else if (rd_active)
    begin
      if (rd_stop || rd_last)
        rd_active <= 1'b0;
      rd_k <= rd_k + COL_W'(1);
    end
  end

  // write burst engine and bad-write check
  logic wr_active, dqm_q1, bad_write, mem_we;
  logic [COL_W-1:0] wr_start, wr_k, wr_col, mem_col;
  logic [1:0] wr_bank, mem_bank;
  logic wr_stop;
  assign wr_col = col_of(wr_start, wr_k, wmask, il);
  assign wr_stop = is_read || is_write || is_bst
    || (is_pre && (addr[sdr_pkg::AP_BIT] || ba == wr_bank));
  assign bad_write = is_write && dq_oe && !dqm_q1;

  // memory write port, masked at once by dqm
  always_comb
  begin
    mem_we = 1'b0;
    mem_col = wr_col;
    mem_bank = wr_bank;
    if (is_write)
    begin
      mem_we = !dqm && !bad_write;
      mem_col = cmd_col;
      mem_bank = ba;
    end
    else if (wr_active && !wr_stop)
    begin
      mem_we = !dqm;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_active <= 1'b0;
      wr_start <= '0;
      wr_k <= '0;
      wr_bank <= '0;
    end
    else if (is_write)
    begin
      wr_active <= !bad_write && (page && !wbm || wmask != '0);
      wr_start <= cmd_col;
      wr_k <= COL_W'(1);
      wr_bank <= ba;
    end
    else if (wr_active)
    begin
      if (wr_stop || (!(page && !wbm) && wr_k == wmask))
        wr_active <= 1'b0;
      wr_k <= wr_k + COL_W'(1);
    end
  end

  // storage, one page per bank
  logic [DQ_W-1:0] mem [NB*(2**COL_W)];
  always_ff @(posedge pclk)
  begin
    if (mem_we)
      mem[{mem_bank, mem_col}] <= dq_in;
  end

  // output pipeline: two stages pick latency two or three
  logic [1:0] pipe_v;
  logic [COL_W-1:0] pipe_col [2];
  logic [1:0] pipe_bank [2];
  logic sel_v;
  logic [COL_W-1:0] sel_col;
  logic [1:0] sel_bank;
  assign sel_v = lat3 ? pipe_v[1] : pipe_v[0];
  assign sel_col = lat3 ? pipe_col[1] : pipe_col[0];
  assign sel_bank = lat3 ? pipe_bank[1] : pipe_bank[0];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pipe_v <= '0;
      pipe_col[0] <= '0;
      pipe_col[1] <= '0;
      pipe_bank[0] <= '0;
      pipe_bank[1] <= '0;
      dqm_q1 <= 1'b0;
    end
    else
    begin
      pipe_v <= {pipe_v[0] && !is_write, emit};
      pipe_col[0] <= e_col;
      pipe_col[1] <= pipe_col[0];
      pipe_bank[0] <= e_bank;
      pipe_bank[1] <= pipe_bank[0];
      dqm_q1 <= dqm;
    end
  end

  // data pin drivers; a registered write turns them off at once
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dq_oe <= 1'b0;
      dq_out <= '0;
    end
    else
    begin
      dq_oe <= sel_v && !dqm_q1 && !is_write;
      dq_out <= mem[{sel_bank, sel_col}];
    end
  end

  // bank open state and row
  logic [NB-1:0] bank_open;
  logic [ADDR_W-1:0] bank_row [NB];
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bank_open <= '0;
      for (int i = 0; i < NB; i++)
        bank_row[i] <= '0;
    end
    else
    begin
      for (int i = 0; i < NB; i++)
      begin
        if (is_act && ba == 2'(i))
        begin
          bank_open[i] <= 1'b1;
          bank_row[i] <= addr;
        end
        else if (is_pre && (addr[sdr_pkg::AP_BIT] || ba == 2'(i)))
          bank_open[i] <= 1'b0;
        else if (ap_close && ap_bank == 2'(i))
          bank_open[i] <= 1'b0;
      end
    end
  end

  // apb handshake and register access
  logic apb_go, apb_wr;
  logic bad_seen;
  logic [31:0] words;
  logic [31:0] status;
  assign apb_go = psel && penable && !pready;
  assign apb_wr = psel && penable && pready && pwrite;
  assign status = {23'h00_0000, lat3, bad_seen,
    mode[sdr_pkg::OPM_LSB +: 2] != sdr_pkg::OPM_NORMAL,
    wr_active, rd_active, bank_open};

  // mode word: pin load wins over a software write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode <= sdr_pkg::MODE_RESET;
    else if (is_lmr)
      mode <= addr[sdr_pkg::MODE_W-1:0];
    else if (apb_wr && paddr == sdr_pkg::REG_MODE)
      mode <= pwdata[sdr_pkg::MODE_W-1:0];
  end

  // sticky bad-write flag and driven-word count; a new bad write beats its clear, a count clear beats a driven word
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bad_seen <= 1'b0;
      words <= '0;
    end
    else
    begin
      if (bad_write)
        bad_seen <= 1'b1;
      else if (apb_wr && paddr == sdr_pkg::REG_STATUS && pwdata[sdr_pkg::ST_BAD_WRITE])
        bad_seen <= 1'b0;
      if (apb_wr && paddr == sdr_pkg::REG_WORDS)
        words <= '0;
      else if (dq_oe)
        words <= words + 32'h0000_0001;
    end
  end

  // answer one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= apb_go;
      pslverr <= apb_go && paddr != sdr_pkg::REG_MODE
        && paddr != sdr_pkg::REG_STATUS && paddr != sdr_pkg::REG_WORDS;
      if (apb_go && !pwrite)
      begin
        case (paddr)
          sdr_pkg::REG_MODE: prdata <= {22'h00_0000, mode};
          sdr_pkg::REG_STATUS: prdata <= status;
          sdr_pkg::REG_WORDS: prdata <= words;
          default: prdata <= '0;
        endcase
      end
    end
  end

  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_lat2_drive: assert property (is_read && !lat3 && !dqm ##1 !is_write |=> dq_oe)
    else $error("latency two read not driven");
  a_lat3_drive: assert property (
    is_read && lat3 ##1 !is_write && !dqm ##1 !is_write |=> dq_oe)
    else $error("latency three read not driven");
  a_write_hiz: assert property (is_write |=> !dq_oe)
    else $error("pins driven after write");
  a_mask_two_clk: assert property (dqm |-> ##2 !dq_oe)
    else $error("mask did not reach drivers in two clocks");
  a_burst_release: assert property ((!emit)[*3] |=> !dq_oe)
    else $error("pins not released after burst");
  a_auto_close: assert property (ap_close && !is_act |=> !bank_open[$past(ap_bank)])
    else $error("auto precharge did not close bank");
  a_page_wrap: assert property (
    rd_active && page && !rd_stop && rd_col == '1 |=> rd_active && rd_col == '0)
    else $error("page burst did not wrap to zero");
  a_write_single: assert property (is_write && wbm |=> !wr_active)
    else $error("single write kept bursting");
  a_burst_four: assert property (
    is_read && bl_code == sdr_pkg::BL_4 ##1 (!rd_stop)[*3] |=> !rd_active)
    else $error("burst of four wrong length");
  a_bst_stop: assert property (is_bst && !is_read |-> !emit)
    else $error("terminate did not stop burst");
  a_mode_fields: assert property (is_lmr |=> lat3 == ($past(addr[6:4]) == sdr_pkg::LAT_3))
    else $error("latency field misread");
  a_mem_mask: assert property (is_write && dqm |-> !mem_we)
    else $error("masked write stored");

  c_read_lat3: cover property (is_read && lat3 ##3 dq_oe);
  c_page_wrap: cover property (rd_active && page && rd_col == '1 ##1 rd_active);
  c_write_trunc: cover property (dq_oe ##0 is_write ##1 !dq_oe);
  c_bst: cover property (rd_active && is_bst);

endmodule
`default_nettype wire

// [test/sdr_ctl_model.sv]
// controller model: command pins, mask level and write data
`timescale 1ns/1ps
`default_nettype none
module sdr_ctl_model (
  input wire logic pclk, // clock
  output logic cs_n, // select
  output logic ras_n, // row strobe
  output logic cas_n, // column strobe
  output logic we_n, // write enable
  output logic [1:0] ba, // bank
  output logic [11:0] addr, // address
  output logic dqm, // byte mask
  input wire logic [15:0] dq_out, // device data
  input wire logic dq_oe, // device drives
  output logic [15:0] dq_in // resolved bus
);
  logic [3:0] pc = 4'h7;
  logic [1:0] pb = 2'h0;
  logic [11:0] pa = 12'h000;
  logic [15:0] pd = 16'h0000;
  logic pe = 1'b0;
  logic mask_lvl = 1'b0;
  logic [15:0] wd = 16'h0000;
  logic drv = 1'b0;
  logic [15:0] last = 16'h0000;
  // nop and a released bus at time zero
  initial
  begin
    {cs_n, ras_n, cas_n, we_n} = 4'h7;
    ba = 2'h0;
    addr = 12'h000;
    dqm = 1'b0;
  end
  // pins move only just after a rising edge
  always @(posedge pclk)
  begin
    {cs_n, ras_n, cas_n, we_n} <= pc;
    ba <= pb;
    addr <= pa;
    dqm <= mask_lvl;
    wd <= pd;
    drv <= pe;
    last <= dq_in;
  end
  // undriven bus keeps changing so stale data never looks valid
  assign dq_in = dq_oe ? dq_out : (drv ? wd : ~last);
  // queue one command for the next edge, then fall back to nop
  task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a,
                       input logic [15:0] d, input logic e);
    pc = c;
    pb = b;
    pa = a;
    pd = d;
    pe = e;
    @(negedge pclk);
    pc = 4'h7;
    pe = 1'b0;
  endtask
endmodule
`default_nettype wire

// [test/sdr_read_path_tb_top.sv]
// self-checking bench for the sdram read path
`timescale 1ns/1ps
`default_nettype none
module sdr_read_path_tb_top;
  localparam logic [3:0] NOP = 4'h7;
  localparam int GAP = 3; // activation and precharge spacing in cycles
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic cs_n, ras_n, cas_n, we_n, dqm, dq_oe, re;
  logic [1:0] ba;
  logic [11:0] addr;
  logic [15:0] dq_in, dq_out;
  logic [15:0] shadow [0:1023];
  int err_total = 0;
  int tests_run = 0;
  sdr_read_path uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr),
    .dqm(dqm), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe)
  );
  sdr_ctl_model ctl (
    .pclk(pclk), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba),
    .addr(addr), .dqm(dqm), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in)
  );
  // free running clock
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask
  task automatic lmr(input logic [11:0] m);
    ctl.issue(sdr_pkg::CMD_LMR, 2'h0, m, 16'h0000, 1'b0);
    repeat (2) @(negedge pclk);
  endtask
  // write burst; kept words land in the shadow copy
  task automatic wr(input logic [1:0] b, input logic [7:0] col, input int n, input int len,
                    input int kept, input logic [15:0] base);
    for (int i = 0; i < n; i++)
    begin
      ctl.issue(i == 0 ? sdr_pkg::CMD_WRITE : NOP, b, {4'h0, col}, base + 16'(i), 1'b1);
      if (i < kept)
        shadow[{b, 8'((col & ~(len - 1)) | ((col + i) & (len - 1)))}] = base + 16'(i);
    end
    if (n < len)
      ctl.issue(sdr_pkg::CMD_BST, b, 12'h000, 16'h0000, 1'b0);
  endtask
  // read burst checked word by word; optional stop command x = latency-1 early
  task automatic rd(input logic [1:0] b, input logic [11:0] a, input int lat, input int cnt,
                    input int len, input logic [3:0] sc, input logic [7:0] sa);
    int c;
    ctl.issue(sdr_pkg::CMD_READ, b, a, 16'h0000, 1'b0);
    for (int j = 2; j <= lat + cnt + 1; j++)
    begin
      if (j - 1 == cnt && sc !== NOP)
        ctl.issue(sc, b, {4'h0, sa}, 16'h0000, 1'b0);
      else
        @(negedge pclk);
      c = (a[7:0] & ~(len - 1)) | ((a[7:0] + j - 1 - lat) & (len - 1));
      if (j > lat && j <= lat + cnt)
        chk("read word", {15'h0, dq_oe, dq_out}, {15'h0, 1'b1, shadow[{b, 8'(c)}]});
    end
    chk("pins after burst", {31'h0, dq_oe}, {31'h0, sc === sdr_pkg::CMD_READ});
    if (sc === sdr_pkg::CMD_READ)
      chk("chained word", {16'h0, dq_out}, {16'h0, shadow[{b, sa}]});
  endtask
  // watchdog
  initial
  begin
    repeat (5000) @(posedge pclk);
    err_total++;
    report_and_stop();
  end
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, sdr_pkg::REG_MODE, 32'h0000_0000);
    chk("mode reset", rv, 32'h0000_0030);
    apb(1'b0, sdr_pkg::REG_STATUS, 32'h0000_0000);
    chk("status reset", rv, 32'h0000_0100);
    apb(1'b0, 8'h0C, 32'h0000_0000);
    chk("unmapped error", {31'h0, re}, 32'h0000_0001);
    $display("test registers done");
    apb(1'b1, sdr_pkg::REG_MODE, 32'h0000_0022);
    ctl.issue(sdr_pkg::CMD_ACT, 2'h1, 12'h005, 16'h0000, 1'b0);
    repeat (GAP) @(negedge pclk);
    wr(2'h1, 8'h08, 4, 4, 4, 16'hA000);
    apb(1'b0, sdr_pkg::REG_STATUS, 32'h0000_0000);
    chk("bank open", rv, 32'h0000_0002);
    rd(2'h1, 12'h009, 2, 4, 4, NOP, 8'h00);
    $display("test latency two done");
    lmr(12'h032);
    rd(2'h1, 12'h008, 3, 4, 4, NOP, 8'h00);
    rd(2'h1, 12'h00A, 3, 2, 4, sdr_pkg::CMD_READ, 8'h08);
    repeat (6) @(negedge pclk);
    $display("test latency three done");
    lmr(12'h027);
    wr(2'h1, 8'hFE, 4, 256, 4, 16'hB000);
    rd(2'h1, 12'h0FE, 2, 4, 256, sdr_pkg::CMD_BST, 8'h00);
    $display("test page done");
    lmr(12'h023);
    ctl.issue(sdr_pkg::CMD_READ, 2'h1, 12'h008, 16'h0000, 1'b0);
    @(negedge pclk);
    ctl.mask_lvl = 1'b1;
    @(negedge pclk);
    chk("before mask", {15'h0, dq_oe, dq_out}, {15'h0, 1'b1, shadow[10'h108]});
    @(negedge pclk);
    chk("mask delay", {15'h0, dq_oe, dq_out}, {15'h0, 1'b1, shadow[10'h109]});
    ctl.mask_lvl = 1'b0;
    ctl.issue(sdr_pkg::CMD_WRITE, 2'h1, 12'h020, 16'h5A5A, 1'b1);
    shadow[10'h120] = 16'h5A5A;
    chk("masked off", {31'h0, dq_oe}, 32'h0000_0000);
    ctl.issue(sdr_pkg::CMD_BST, 2'h1, 12'h000, 16'h0000, 1'b0);
    chk("write holds off", {31'h0, dq_oe}, 32'h0000_0000);
    rd(2'h1, 12'h020, 2, 1, 8, sdr_pkg::CMD_BST, 8'h00);
    $display("test mask done");
    rd(2'h1, 12'h008, 2, 3, 8, sdr_pkg::CMD_PRE, 8'h00);
    apb(1'b0, sdr_pkg::REG_STATUS, 32'h0000_0000);
    chk("bank closed", rv, 32'h0000_0000);
    repeat (GAP) @(negedge pclk);
    lmr(12'h021);
    ctl.issue(sdr_pkg::CMD_ACT, 2'h1, 12'h006, 16'h0000, 1'b0);
    repeat (GAP) @(negedge pclk);
    wr(2'h1, 8'h40, 2, 2, 2, 16'hC000);
    lmr(12'h221);
    wr(2'h1, 8'h40, 2, 2, 1, 16'hD000);
    rd(2'h1, 12'h440, 2, 2, 2, NOP, 8'h00);
    apb(1'b0, sdr_pkg::REG_STATUS, 32'h0000_0000);
    chk("auto precharge", rv, 32'h0000_0000);
    $display("test single write done");
    report_and_stop();
  end
endmodule
`default_nettype wire
